// *** src/flash_front_pkg.sv ***
package flash_front_pkg;
  localparam int PAGE_BITS = 13;
  localparam int BYTE_BITS = 10;
  localparam int ADDR_BITS = 24;
  localparam int PAGE_MSB_POS = 22;
  localparam int BYTE_MSB_POS = 9;
  localparam logic MODE_RESET = 1'b1;
  localparam int DUMMY_BUF = 1;
  localparam int DUMMY_ARR = 4;
  localparam int CLK_MHZ = 100;
  localparam int WRITE_WAIT_MS = 20;
  localparam int WRITE_WAIT_CYC = WRITE_WAIT_MS * 1000 * CLK_MHZ;
  localparam int SELECT_WAIT_US = 70;
  localparam int SUPPLY_TO_SELECT_WAIT_CYC = SELECT_WAIT_US * CLK_MHZ;
  typedef enum logic [1:0] {
    ADDR_NONE, ADDR_PAGE, ADDR_BYTE, ADDR_BOTH
  } addr_kind_e;
  typedef struct packed {
    addr_kind_e kind;
    logic [2:0] dummies;
    logic is_write;
    logic reads_out;
  } cmd_info_s;
  function automatic cmd_info_s decode_cmd(input logic [7:0] op);
    cmd_info_s d;
    d = '{ADDR_NONE, 3'h0, 1'b0, 1'b0};
    unique case (op)
      8'h83, 8'h86, 8'h88, 8'h89: d = '{ADDR_PAGE, 3'h0, 1'b1, 1'b0};
      8'h84, 8'h87: d = '{ADDR_BYTE, 3'h0, 1'b0, 1'b0};
      8'hD1: d = '{ADDR_BYTE, 3'h0, 1'b0, 1'b1};
      8'hD4, 8'hD6: d = '{ADDR_BYTE, 3'(DUMMY_BUF), 1'b0, 1'b1};
      8'h85: d = '{ADDR_BOTH, 3'h0, 1'b1, 1'b0};
      8'hD2, 8'hE8: d = '{ADDR_BOTH, 3'(DUMMY_ARR), 1'b0, 1'b1};
      8'h9F, 8'hD7: d = '{ADDR_NONE, 3'h0, 1'b0, 1'b1};
      default: d = '{ADDR_NONE, 3'h0, 1'b0, 1'b0};
    endcase
    return d;
  endfunction
endpackage

// *** src/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 3
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      meta_r <= '1;
      q <= '1;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// *** src/flash_cmd_front.sv ***
`timescale 1ns/1ps
module flash_cmd_front
  import flash_front_pkg::*;
#(
  parameter int WRITE_WAIT = WRITE_WAIT_CYC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  output logic so_o,
  output logic so_oe_n,
  output logic mode3,
  output logic cmd_valid,
  output logic [7:0] cmd_op,
  output logic [PAGE_BITS-1:0] page_addr,
  output logic [BYTE_BITS-1:0] byte_addr,
  output logic write_refused,
  output logic standby
);
  typedef enum logic [2:0] {
    ST_WAIT_CS, ST_OPCODE, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE
  } st_e;
  typedef struct packed {
    st_e st;
    logic cs_q;
    logic sck_q;
    logic mode3;
    logic [7:0] sh;
    logic [4:0] bits;
    logic [2:0] dums;
    logic [7:0] op;
    cmd_info_s info;
    logic [ADDR_BITS-1:0] addr;
    logic cmd_valid;
    logic [PAGE_BITS-1:0] page;
    logic [BYTE_BITS-1:0] byte_a;
    logic wr_ref;
    logic so_oe_n;
    logic [31:0] pwr_cnt;
    logic wr_ok;
    logic stby;
    logic so_d;
  } state_s;
  state_s s_r, s_nxt;
  logic cs_s, sck_s, si_s;
  logic cs_fall, sck_rise;
  logic [7:0] op_in;
  cmd_info_s op_dec;
  pin_sync #(.W(3)) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .d({cs_n, sck, si}),
    .q({cs_s, sck_s, si_s})
  );
  // cs_s leaves reset high, so ST_IGNORE ends at once and a select already low when reset ends still starts an instruction
  assign cs_fall = s_r.cs_q && !cs_s && (s_r.st != ST_IGNORE);
  assign op_in = {s_r.sh[6:0], si_s};
  assign op_dec = decode_cmd(op_in);
  assign sck_rise = !s_r.sck_q && sck_s;
  always_comb begin
    s_nxt = s_r;
    s_nxt.cs_q = cs_s;
    s_nxt.sck_q = sck_s;
    s_nxt.cmd_valid = 1'b0;
    s_nxt.wr_ref = 1'b0;
    s_nxt.so_d = 1'b0;
    if (!s_r.wr_ok) begin
      if (s_r.pwr_cnt >= 32'(WRITE_WAIT - 1)) begin
        s_nxt.wr_ok = 1'b1;
      end else begin
        s_nxt.pwr_cnt = s_r.pwr_cnt + 32'd1;
      end
    end
    if (cs_s) begin
      s_nxt.st = ST_WAIT_CS;
      s_nxt.so_oe_n = 1'b1;
    end else if (cs_fall) begin
      s_nxt.mode3 = sck_s;
      s_nxt.st = ST_OPCODE;
      s_nxt.bits = 5'd0;
    end else if (sck_rise) begin
      unique case (s_r.st)
        ST_OPCODE: begin
          s_nxt.sh = {s_r.sh[6:0], si_s};
          s_nxt.bits = s_r.bits + 5'd1;
          if (s_r.bits == 5'd7) begin
            s_nxt.op = op_in;
            s_nxt.info = op_dec;
            s_nxt.bits = 5'd0;
            s_nxt.dums = op_dec.dummies;
            s_nxt.st = (op_dec.kind == ADDR_NONE)
              ? ST_DATA : ST_ADDR;
          end
        end
        ST_ADDR: begin
          s_nxt.addr = {s_r.addr[ADDR_BITS-2:0], si_s};
          s_nxt.bits = s_r.bits + 5'd1;
          if (s_r.bits == 5'(ADDR_BITS - 1)) begin
            s_nxt.bits = 5'd0;
            s_nxt.st = (s_r.dums != 3'd0) ? ST_DUMMY : ST_DATA;
          end
        end
        ST_DUMMY: begin
          s_nxt.bits = s_r.bits + 5'd1;
          if (s_r.bits == 5'd7) begin
            s_nxt.bits = 5'd0;
            s_nxt.dums = s_r.dums - 3'd1;
            if (s_r.dums == 3'd1) begin
              s_nxt.st = ST_DATA;
            end
          end
        end
        default: ;
      endcase
    end
    if (s_r.st != ST_DATA && s_nxt.st == ST_DATA) begin
      s_nxt.cmd_valid = !(s_r.info.is_write && !s_r.wr_ok);
      s_nxt.wr_ref = s_r.info.is_write && !s_r.wr_ok;
      s_nxt.page = '0;
      s_nxt.byte_a = '0;
      if (s_r.info.kind == ADDR_PAGE || s_r.info.kind == ADDR_BOTH) begin
        s_nxt.page = s_nxt.addr[PAGE_MSB_POS -: PAGE_BITS];
      end
      if (s_r.info.kind == ADDR_BYTE || s_r.info.kind == ADDR_BOTH) begin
        s_nxt.byte_a = s_nxt.addr[BYTE_MSB_POS:0];
      end
      s_nxt.so_oe_n = !s_r.info.reads_out;
    end
    if (s_r.st == ST_OPCODE && s_nxt.st == ST_DATA) begin
      // Old command info must not leak a refusal into this header
      s_nxt.cmd_valid = 1'b1;
      s_nxt.wr_ref = 1'b0;
      s_nxt.page = '0;
      s_nxt.byte_a = '0;
      s_nxt.so_oe_n = !s_nxt.info.reads_out;
    end
    s_nxt.stby = (s_nxt.st == ST_WAIT_CS) || (s_nxt.st == ST_IGNORE);
  end
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      s_r <= '0;
      s_r.st <= ST_IGNORE;
      s_r.cs_q <= 1'b1;
      s_r.sck_q <= 1'b1;
      s_r.mode3 <= MODE_RESET;
      s_r.so_oe_n <= 1'b1;
      s_r.stby <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign so_o = s_r.so_d;
  assign so_oe_n = s_r.so_oe_n;
  assign mode3 = s_r.mode3;
  assign cmd_valid = s_r.cmd_valid;
  assign cmd_op = s_r.op;
  assign page_addr = s_r.page;
  assign byte_addr = s_r.byte_a;
  assign write_refused = s_r.wr_ref;
  assign standby = s_r.stby;

  property p_reset_mode;
    @(posedge ref_clk) !resetn |=> mode3 && so_oe_n;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("mode");
  property p_so_idle;
    @(posedge ref_clk) disable iff (!resetn) cs_s |=> so_oe_n;
  endproperty
  a_so_idle: assert property (p_so_idle) else $error("so driven");
  property p_cs_fall_mode;
    @(posedge ref_clk) disable iff (!resetn) cs_fall |=> mode3 == $past(sck_s);
  endproperty
  a_cs_fall_mode: assert property (p_cs_fall_mode) else $error("m");
  property p_no_cmd_idle;
    @(posedge ref_clk) disable iff (!resetn)
      (s_r.st == ST_WAIT_CS) |=> !cmd_valid;
  endproperty
  a_no_cmd_idle: assert property (p_no_cmd_idle) else $error("c");
  property p_ignore;
    @(posedge ref_clk) disable iff (!resetn)
      $rose(resetn) |-> !cmd_valid [*2];
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignore");
  property p_wr_refuse;
    @(posedge ref_clk) disable iff (!resetn)
      write_refused |-> !cmd_valid && !$past(s_r.wr_ok);
  endproperty
  a_wr_refuse: assert property (p_wr_refuse) else $error("w");
  property p_page_only;
    @(posedge ref_clk) disable iff (!resetn)
      cmd_valid && cmd_op == 8'h83 |-> byte_addr == '0;
  endproperty
  a_page_only: assert property (p_page_only) else $error("p");
  property p_buf_only;
    @(posedge ref_clk) disable iff (!resetn)
      cmd_valid && (cmd_op == 8'hD4 || cmd_op == 8'hD6) |-> page_addr == '0;
  endproperty
  a_buf_only: assert property (p_buf_only) else $error("b");
  property p_standby;
    @(posedge ref_clk) disable iff (!resetn) cs_s |=> standby;
  endproperty
  a_standby: assert property (p_standby) else $error("s");
  c_cmd: cover property (@(posedge ref_clk) cmd_valid);
  c_mode0: cover property (@(posedge ref_clk) !mode3);
  c_refuse: cover property (@(posedge ref_clk) write_refused);
endmodule

// *** tb/spi_host_model.sv ***
`timescale 1ns/1ps
module spi_host_model (
  output logic cs_n,
  output logic sck,
  output logic si
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b1;
    si = 1'b0;
  end
  // Clock rests at its idle level outside frames
  task automatic frame(input logic sel, input logic idle,
                       input logic [63:0] bits, input int n);
    sck = idle;
    #80;
    cs_n = ~sel;
    #80;
    for (int i = n - 1; i >= 0; i--) begin
      sck = 1'b0;
      si = bits[i];
      #80;
      sck = 1'b1;
      #80;
    end
    sck = idle;
    #80;
    cs_n = 1'b1;
    si = ~si;
    #400;
  endtask
endmodule

// *** tb/serial_flash_cmd_addr_powerup_bench.sv ***
`timescale 1ns/1ps
module serial_flash_cmd_addr_powerup_bench;
  import flash_front_pkg::*;
  localparam int WAIT_CYC = 10000;
  logic ref_clk, resetn, cs_n, sck, si, so_o, so_oe_n, mode3, cmd_valid;
  logic write_refused, standby, oe_seen;
  logic [7:0] cmd_op;
  logic [PAGE_BITS-1:0] page_addr;
  logic [BYTE_BITS-1:0] byte_addr;
  int err_total = 0, comparisons = 0, n_valid = 0, n_ref = 0;
  spi_host_model host (.cs_n(cs_n), .sck(sck), .si(si));
  flash_cmd_front #(.WRITE_WAIT(WAIT_CYC)) DUT (
    .ref_clk(ref_clk), .resetn(resetn), .cs_n(cs_n), .sck(sck), .si(si),
    .so_o(so_o), .so_oe_n(so_oe_n), .mode3(mode3), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .page_addr(page_addr), .byte_addr(byte_addr),
    .write_refused(write_refused), .standby(standby));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Count on the falling edge so a one-cycle pulse is seen exactly once
  always @(negedge ref_clk) begin
    if (cmd_valid === 1'b1) n_valid++;
    if (write_refused === 1'b1) n_ref++;
    if (so_oe_n === 1'b0) oe_seen = 1'b1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d, errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One frame; ad address bits and nd dummy bytes follow the opcode
  task automatic run(input logic sel, input logic idle, input logic [7:0] op,
      input logic [23:0] a, input int nd, input int ad, input int ev);
    int v0;
    logic [63:0] b;
    v0 = n_valid;
    oe_seen = 1'b0;
    b = {32'h0, op, a} >> (24 - ad);
    b = b << (8 * nd);
    @(posedge ref_clk) #1;
    host.frame(sel, idle, b, 8 + ad + 8 * nd);
    chk(32'(n_valid - v0), 32'(ev));
  endtask
  task automatic t_reset;
    chk(32'(mode3), 32'h1);
    chk(32'(so_oe_n), 32'h1);
    chk(32'(standby), 32'h1);
  endtask
  task automatic t_early;
    run(1'b1, 1'b1, 8'h83, {1'b1, 13'h1ABC, 10'h3FF}, 0, 24, 0);
    chk(32'(n_ref), 32'h1);
    chk(32'(standby), 32'h1);
  endtask
  task automatic t_modes;
    run(1'b0, 1'b0, 8'h9F, 24'h0, 0, 0, 0);
    run(1'b1, 1'b0, 8'h9F, 24'h0, 0, 0, 1);
    chk(32'(mode3), 32'h0);
    chk(32'(cmd_op), 32'h9F);
    chk(32'(oe_seen), 32'h1);
    chk(32'(so_oe_n), 32'h1);
    chk(32'(so_o), 32'h0);
    run(1'b1, 1'b1, 8'hD7, 24'h0, 0, 0, 1);
    chk(32'(mode3), 32'h1);
  endtask
  task automatic t_write;
    repeat (WAIT_CYC) @(posedge ref_clk);
    run(1'b1, 1'b1, 8'h85, {1'b1, 13'h1ABC, 10'h2A5}, 0, 24, 1);
    chk(32'(page_addr), 32'h1ABC);
    chk(32'(byte_addr), 32'h2A5);
    run(1'b1, 1'b0, 8'h83, {1'b1, 13'h0F0F, 10'h3FF}, 0, 24, 1);
    chk(32'(page_addr), 32'h0F0F);
    chk(32'(byte_addr), 32'h0);
    chk(32'(n_ref), 32'h1);
  endtask
  task automatic t_buffer;
    run(1'b1, 1'b1, 8'h84, {1'b1, 13'h1FFF, 10'h155}, 0, 24, 1);
    chk(32'(page_addr), 32'h0);
    chk(32'(byte_addr), 32'h155);
    run(1'b1, 1'b1, 8'hD4, 24'h0000AA, 0, 24, 0);
    run(1'b1, 1'b1, 8'hD6, 24'h0000AA, 1, 24, 1);
    chk(32'(oe_seen), 32'h1);
    run(1'b1, 1'b0, 8'hD2, {1'b0, 13'h0123, 10'h0F0}, 3, 24, 0);
    run(1'b1, 1'b0, 8'hE8, {1'b0, 13'h0123, 10'h0F0}, 4, 24, 1);
    chk(32'(page_addr), 32'h0123);
    chk(32'(byte_addr), 32'h0F0);
  endtask
  // Frame during a second reset, then the write wait restarts
  task automatic t_reset_mid;
    @(posedge ref_clk) #1;
    resetn = 1'b0;
    run(1'b1, 1'b0, 8'h9F, 24'h0, 0, 0, 0);
    chk(32'(mode3), 32'h1);
    chk(32'(so_oe_n), 32'h1);
    chk(32'(standby), 32'h1);
    @(posedge ref_clk) #1;
    resetn = 1'b1;
    repeat (SUPPLY_TO_SELECT_WAIT_CYC) @(posedge ref_clk);
    run(1'b1, 1'b1, 8'h88, {1'b0, 13'h0555, 10'h000}, 0, 24, 0);
    chk(32'(n_ref), 32'h2);
  endtask
  initial begin
    resetn = 1'b0;
    oe_seen = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1 resetn = 1'b1;
    t_reset();
    repeat (SUPPLY_TO_SELECT_WAIT_CYC) @(posedge ref_clk);
    t_early();
    t_modes();
    t_write();
    t_buffer();
    t_reset_mid();
    wrap_up();
  end
  initial begin
    #600us;
    err_total++;
    wrap_up();
  end
endmodule
